// File: pkg/slpi_pkg.sv
// Constants for the seven-level priority interrupt unit.
// Assumes a 36-bit word machine whose control words are carried in the low 32 bits of an AHB-Lite word.
package slpi_pkg;
    localparam int NLVL = 7;
    // Register byte offsets.
    localparam logic [7:0] OFF_COND = 8'h00;
    localparam logic [7:0] OFF_STAT = 8'h04;
    localparam logic [7:0] OFF_DISM = 8'h08;
    localparam logic [7:0] OFF_EPT = 8'h0c;
    localparam logic [7:0] OFF_HALT = 8'h10;
    // Write-conditions operand: word bit k sits at position 35-k.
    localparam int C_CLR_PREQ = 13;
    localparam int C_CLR_ALL = 12;
    localparam int C_SET_PREQ = 11;
    localparam int C_LVL_ON = 10;
    localparam int C_LVL_OFF = 9;
    localparam int C_SYS_OFF = 8;
    localparam int C_SYS_ON = 7;
    localparam int LVL_TOP = 6;
    // Status word layout.
    localparam int S_PREQ_TOP = 24;
    localparam int S_HELD_TOP = 14;
    localparam int S_SYS_ON = 7;
    // Halt register bits.
    localparam int H_ILL_INT = 0;
    localparam int H_ILL_INS = 1;
    localparam int H_BUSY = 2;
    // Dismiss register: set for the exchange variant.
    localparam int D_XCHG = 0;
    // Executive table words.
    localparam logic [6:0] EPT_LVL_BASE = 7'h20;
    localparam logic [6:0] EPT_ADP_BASE = 7'h40;
    // Instruction word fields.
    localparam int OP_HI = 35;
    localparam int OP_LO = 27;
    localparam int AC_HI = 26;
    localparam int AC_LO = 23;
    localparam int Y_HI = 17;
    localparam int VEC_SHIFT = 2;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_POLL = 7'h02,
        ST_VEC = 7'h04,
        ST_TAB = 7'h08,
        ST_INS = 7'h10,
        ST_HALT = 7'h20,
        ST_DONE = 7'h40
    } slpi_state_type;
endpackage

// File: hw/slpi_top.sv
// Seven-level priority interrupt unit with an AHB-Lite register port.
// Assumes adapters answer poll and vector cycles and memory answers table reads by acknowledge pulses.
//
// Functional notes
// RULE1: Seven levels, 1 highest; level 0 means no interrupt connection.
// RULE2: Hardware requests are recognized only on levels that are on.
// RULE3: Recognition continues while the system is off; highest served first later.
// RULE4: One request at a time, only above the running program level.
// RULE5: On accept halt program, disable system, poll bus with level.
// RULE6: Adapters 0 to 3 answer the poll on their own lines.
// RULE7: No poll answer means internal; use table word 40+2N.
// RULE8: Nonzero answer picks lowest adapter and sends it a vector request.
// RULE9: Instruction address is table base from word 100+N plus vector/4.
// RULE10: Zero table base gives an illegal-interrupt halt.
// RULE11: Only jump-and-save or PC exchange are legal interrupt instructions.
// RULE12: Legal instruction holds level, re-enables system, jumps to target.
// RULE13: Interrupt instruction runs executive; exchange takes mode from flags.
// RULE14: Write-conditions acts on one bits only; bits 29-35 select levels.
// RULE15: Bit 22 clears program requests on selected levels.
// RULE16: Bit 23 disables system, levels off, drops requests, releases holds.
// RULE17: Bit 24 sets persistent program requests, recognized even when off.
// RULE18: Forced top-level request lets at most one more instruction run.
// RULE19: Bit 25 turns selected levels on; bit 26 turns them off.
// RULE20: Bit 27 disables the system; bit 28 enables it.
// RULE21: Status gives requests, holds, system-on, levels-on; rest zero.
// RULE22: Held level blocks itself and lower levels until dismissed.
// RULE23: Both dismiss variants release the held level and return.
// RULE24: Dismiss restores flags from doubleword or from PC word half.
// RULE25: A dismiss releases only the highest-priority held level.
//
// Implementation choices: the AHB-Lite interface to the registers and the register offsets.
module slpi_top #(
    parameter int ADR_W = 18,
    parameter int VEC_W = 16,
    parameter logic [8:0] OPC_JSAVE = 9'h0b4,
    parameter logic [8:0] OPC_JUMP_AND_RESTORE = 9'h0ac,
    parameter logic [3:0] AC_EXCHANGE_PC_WORD = 4'h5
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [slpi_pkg::NLVL-1:0] hw_req,
    input wire logic cpu_ready,
    output logic prog_halt,
    output logic poll_valid,
    output logic [2:0] poll_level,
    input wire logic poll_ack,
    input wire logic [3:0] poll_resp,
    output logic vec_valid,
    output logic [1:0] vec_adapter,
    input wire logic vec_ack,
    input wire logic [VEC_W-1:0] vec_data,
    output logic mem_rd,
    output logic [ADR_W-1:0] mem_addr,
    input wire logic mem_ack,
    input wire logic [35:0] mem_data,
    output logic start_valid,
    output logic [ADR_W-1:0] start_pc,
    output logic start_mode_from_flags,
    output logic restore_valid,
    output logic restore_from_dword
);
    import slpi_pkg::*;

    if (ADR_W < 8 || ADR_W > 18 || VEC_W < 3) begin : g_bad
        $error("slpi_top: unsupported address or vector width");
    end

    slpi_state_type st_r;
    logic [NLVL-1:0] lvl_on_r;
    logic [NLVL-1:0] preq_r;
    logic [NLVL-1:0] held_r;
    logic sys_on_r;
    logic [2:0] lvl_r;
    logic [1:0] adp_r;
    logic [ADR_W-1:0] vofs_r;
    logic [ADR_W-1:0] ept_r;
    logic ill_int_r;
    logic ill_ins_r;
    logic d_wr_r;
    logic [7:0] d_addr_r;
    logic [NLVL-1:0] recog;
    logic [NLVL-1:0] blk;
    logic [NLVL-1:0] sel;
    logic [NLVL-1:0] dism_mask;
    logic [2:0] pick;
    logic found;
    logic ok;
    logic accept_go;
    logic legal_go;
    logic wr_cond;
    logic wr_dism;
    logic [8:0] opc;
    logic [3:0] ac;
    logic legal;
    logic [31:0] rd_nxt;
    logic [31:0] status;

    // Operand selection and status levels-on map level i+1 to position LVL_TOP-i; requests and holds to S_PREQ_TOP-i and S_HELD_TOP-i.
    for (genvar i = 0; i < NLVL; i++) begin : g_map
        assign sel[i] = hwdata[LVL_TOP-i];
        assign status[S_PREQ_TOP-i] = preq_r[i];
        assign status[S_HELD_TOP-i] = held_r[i];
        assign status[LVL_TOP-i] = lvl_on_r[i];
    end
    // RULE21: unused status zero
    assign status[31:S_PREQ_TOP+1] = '0;
    assign status[S_PREQ_TOP-NLVL:S_HELD_TOP+1] = '0;
    assign status[S_SYS_ON] = sys_on_r;

    assign wr_cond = d_wr_r && d_addr_r == OFF_COND;
    assign wr_dism = d_wr_r && d_addr_r == OFF_DISM;

    // Index 0 is level 1, so the lowest set index has the highest priority.
    always_comb begin
        // RULE2: gate hardware requests
        // RULE17: program requests bypass level-on
        recog = (hw_req & lvl_on_r) | preq_r;
        found = 1'b0;
        ok = 1'b0;
        pick = '0;
        dism_mask = '0;
        for (int i = 0; i < NLVL; i++) begin
            // RULE22: hold blocks lower levels
            blk[i] = (i == 0) ? held_r[0] : (blk[i-1] | held_r[i]);
            if (!found && recog[i]) begin
                found = 1'b1;
                pick = 3'(i);
                ok = !blk[i];
            end
        end
        // RULE25: release top held only
        for (int i = NLVL - 1; i >= 0; i--) begin
            if (held_r[i]) begin
                dism_mask = '0;
                dism_mask[i] = 1'b1;
            end
        end
    end

    // RULE4: one at a time, above program
    // RULE3: pending served once system on
    // RULE18: accepted at next instruction boundary
    assign accept_go = st_r == ST_IDLE && found && ok && sys_on_r && cpu_ready;

    assign opc = mem_data[OP_HI:OP_LO];
    assign ac = mem_data[AC_HI:AC_LO];
    // RULE11: legal interrupt opcodes
    assign legal = opc == OPC_JSAVE || (opc == OPC_JUMP_AND_RESTORE && ac == AC_EXCHANGE_PC_WORD);
    assign legal_go = st_r == ST_INS && mem_ack && legal;

    // Interrupt sequence.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= ST_IDLE;
            lvl_r <= '0;
            adp_r <= '0;
            vofs_r <= '0;
            prog_halt <= 1'b0;
            poll_valid <= 1'b0;
            poll_level <= '0;
            vec_valid <= 1'b0;
            vec_adapter <= '0;
            mem_rd <= 1'b0;
            mem_addr <= '0;
            start_valid <= 1'b0;
            start_pc <= '0;
            start_mode_from_flags <= 1'b0;
            ill_int_r <= 1'b0;
            ill_ins_r <= 1'b0;
        end else begin
            start_valid <= 1'b0;
            unique case (st_r)
                ST_IDLE: begin
                    if (accept_go) begin
                        // RULE5: halt and poll
                        lvl_r <= pick + 3'h1;
                        prog_halt <= 1'b1;
                        poll_valid <= 1'b1;
                        poll_level <= pick + 3'h1;
                        st_r <= ST_POLL;
                    end
                end
                ST_POLL: begin
                    if (poll_ack) begin
                        poll_valid <= 1'b0;
                        if (poll_resp == 4'h0) begin
                            // RULE7: internal request slot
                            mem_addr <= ept_r + ADR_W'(EPT_LVL_BASE) + ADR_W'({lvl_r, 1'b0});
                            mem_rd <= 1'b1;
                            st_r <= ST_INS;
                        end else begin
                            // RULE6: adapter answer lines
                            // RULE8: lowest adapter wins
                            vec_valid <= 1'b1;
                            if (poll_resp[0]) begin
                                vec_adapter <= 2'h0;
                                adp_r <= 2'h0;
                            end else if (poll_resp[1]) begin
                                vec_adapter <= 2'h1;
                                adp_r <= 2'h1;
                            end else if (poll_resp[2]) begin
                                vec_adapter <= 2'h2;
                                adp_r <= 2'h2;
                            end else begin
                                vec_adapter <= 2'h3;
                                adp_r <= 2'h3;
                            end
                            st_r <= ST_VEC;
                        end
                    end
                end
                ST_VEC: begin
                    if (vec_ack) begin
                        vec_valid <= 1'b0;
                        // RULE9: vector quartered
                        vofs_r <= ADR_W'(vec_data >> VEC_SHIFT);
                        mem_addr <= ept_r + ADR_W'(EPT_ADP_BASE) + ADR_W'(adp_r);
                        mem_rd <= 1'b1;
                        st_r <= ST_TAB;
                    end
                end
                ST_TAB: begin
                    if (mem_ack) begin
                        if (mem_data[ADR_W-1:0] == '0) begin
                            // RULE10: zero base halts
                            mem_rd <= 1'b0;
                            ill_int_r <= 1'b1;
                            st_r <= ST_HALT;
                        end else begin
                            // RULE9: base plus offset
                            mem_addr <= mem_data[ADR_W-1:0] + vofs_r;
                            st_r <= ST_INS;
                        end
                    end
                end
                ST_INS: begin
                    if (mem_ack) begin
                        mem_rd <= 1'b0;
                        if (legal) begin
                            // RULE12: jump to target
                            // RULE13: executive or flag mode
                            start_valid <= 1'b1;
                            start_pc <= mem_data[Y_HI-(18-ADR_W):0];
                            start_mode_from_flags <= opc != OPC_JSAVE;
                            prog_halt <= 1'b0;
                            st_r <= ST_DONE;
                        end else begin
                            ill_ins_r <= 1'b1;
                            st_r <= ST_HALT;
                        end
                    end
                end
                ST_DONE: begin
                    st_r <= ST_IDLE;
                end
                ST_HALT: begin
                    // The program stays halted; only clear-all restarts it.
                    if (wr_cond && hwdata[C_CLR_ALL]) begin
                        ill_int_r <= 1'b0;
                        ill_ins_r <= 1'b0;
                        prog_halt <= 1'b0;
                        st_r <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // System on flag; hardware events after software so re-enable is not lost.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sys_on_r <= 1'b0;
        end else begin
            if (wr_cond) begin
                // RULE14: one bits act
                // RULE20: system off and on
                if (hwdata[C_SYS_ON]) begin
                    sys_on_r <= 1'b1;
                end
                if (hwdata[C_SYS_OFF] || hwdata[C_CLR_ALL]) begin
                    sys_on_r <= 1'b0;
                end
            end
            // RULE5: disable on accept
            if (accept_go) begin
                sys_on_r <= 1'b0;
            end
            // RULE12: re-enable on start
            if (legal_go) begin
                sys_on_r <= 1'b1;
            end
        end
    end

    // Level on mask and program requests.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lvl_on_r <= '0;
            preq_r <= '0;
        end else if (wr_cond) begin
            // RULE1: seven level masks
            // RULE19: level on and off
            // RULE15: clear program requests
            // RULE17: persistent requests
            // RULE16: clear all
            if (hwdata[C_CLR_ALL]) begin
                lvl_on_r <= '0;
                preq_r <= '0;
            end else begin
                lvl_on_r <= (lvl_on_r | (hwdata[C_LVL_ON] ? sel : '0)) & ~(hwdata[C_LVL_OFF] ? sel : '0);
                preq_r <= (preq_r & ~(hwdata[C_CLR_PREQ] ? sel : '0)) | (hwdata[C_SET_PREQ] ? sel : '0);
            end
        end
    end

    // Held levels; a new hold wins over a release in the same cycle.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            held_r <= '0;
            restore_valid <= 1'b0;
            restore_from_dword <= 1'b0;
        end else begin
            restore_valid <= 1'b0;
            if (wr_cond && hwdata[C_CLR_ALL]) begin
                held_r <= legal_go ? (NLVL'(1) << (lvl_r - 3'h1)) : '0;
            end else begin
                // RULE23: dismiss releases
                // RULE24: flag restore source
                if (wr_dism) begin
                    restore_valid <= 1'b1;
                    restore_from_dword <= hwdata[D_XCHG];
                end
                // RULE12: hold level
                held_r <= (held_r & ~(wr_dism ? dism_mask : '0)) | (legal_go ? (NLVL'(1) << (lvl_r - 3'h1)) : '0);
            end
        end
    end

    // AHB-Lite slave: zero wait states, always OKAY.
    always_comb begin
        unique case (haddr[7:0])
            OFF_STAT: rd_nxt = status;
            OFF_EPT: rd_nxt = 32'(ept_r);
            OFF_HALT: rd_nxt = {29'h0, st_r != ST_IDLE, ill_ins_r, ill_int_r};
            default: rd_nxt = '0;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            d_wr_r <= 1'b0;
            d_addr_r <= '0;
            hrdata <= '0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else if (hready) begin
            d_wr_r <= hsel && htrans == HTRANS_NONSEQ && hwrite;
            d_addr_r <= haddr[7:0];
            hrdata <= (hsel && htrans == HTRANS_NONSEQ && !hwrite) ? rd_nxt : '0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ept_r <= '0;
        end else if (d_wr_r && d_addr_r == OFF_EPT) begin
            ept_r <= hwdata[ADR_W-1:0];
        end
    end
endmodule

// File: tb/slpi_checker.sv
// Port-level assertions for the seven-level interrupt unit.
// Assumes one clock domain; bound onto the top module's ports.
module slpi_checker
    import slpi_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic prog_halt,
    input wire logic poll_valid,
    input wire logic [2:0] poll_level,
    input wire logic poll_ack,
    input wire logic [3:0] poll_resp,
    input wire logic vec_valid,
    input wire logic [1:0] vec_adapter,
    input wire logic vec_ack,
    input wire logic mem_rd,
    input wire logic start_valid,
    input wire logic restore_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] low_adp;
    logic dism_wr;
    // The lowest-numbered answering adapter wins within a level.
    assign low_adp = poll_resp[0] ? 2'h0 : poll_resp[1] ? 2'h1 : poll_resp[2] ? 2'h2 : 2'h3;
    assign dism_wr = hsel && hready && htrans == HTRANS_NONSEQ && hwrite && haddr == {24'h0, OFF_DISM};
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    level_range_a: assert property (poll_valid |-> poll_level inside {[3'h1:3'h7]})
        else $error("poll level outside 1 to 7");
    one_at_once_a: assert property ($rose(poll_valid) |-> !$past(prog_halt))
        else $error("accept while a sequence was running");
    halt_on_poll_a: assert property ($rose(poll_valid) |-> prog_halt)
        else $error("poll without program halt");
    poll_hold_a: assert property (poll_valid && !poll_ack |=> poll_valid)
        else $error("poll dropped before answer");
    internal_path_a: assert property (poll_valid && poll_ack && poll_resp == 4'h0 |=> mem_rd && !vec_valid)
        else $error("empty poll answer did not read table");
    vec_pick_a: assert property (poll_valid && poll_ack && poll_resp != 4'h0 |=> vec_valid && vec_adapter == $past(low_adp))
        else $error("wrong adapter in vector cycle");
    vec_to_table_a: assert property (vec_valid && vec_ack |=> mem_rd && !vec_valid)
        else $error("vector answer did not read table base");
    start_pulse_a: assert property (start_valid |-> !prog_halt ##1 !start_valid)
        else $error("start not a single pulse with program running");
    dismiss_pulse_a: assert property (dism_wr |=> ##1 restore_valid)
        else $error("dismiss write gave no restore pulse");
endmodule
bind slpi_top slpi_checker chk (.*);

// File: tb/slpi_adapters.sv
// Behavioural bus adapters and physical memory facing the interrupt unit.
// Assumes the bench loads mem and sets request mask, level and answer delay.
module slpi_adapters (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [3:0] adp_mask,
    input wire logic [2:0] adp_level,
    input wire logic [3:0] dly,
    input wire logic poll_valid,
    input wire logic [2:0] poll_level,
    output logic poll_ack,
    output logic [3:0] poll_resp,
    input wire logic vec_valid,
    input wire logic [1:0] vec_adapter,
    output logic vec_ack,
    output logic [15:0] vec_data,
    input wire logic mem_rd,
    input wire logic [17:0] mem_addr,
    output logic mem_ack,
    output logic [35:0] mem_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [35:0] mem [0:1023];
    logic [3:0] wait_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wait_r <= 4'h0;
            poll_ack <= 1'b0;
            vec_ack <= 1'b0;
            mem_ack <= 1'b0;
            poll_resp <= 4'h0;
            vec_data <= 16'h0;
            mem_data <= 36'h0;
        end else begin
            poll_ack <= 1'b0;
            vec_ack <= 1'b0;
            mem_ack <= 1'b0;
            // Released lines toggle so a stale value never passes for an answer.
            poll_resp <= ~poll_resp;
            vec_data <= ~vec_data;
            mem_data <= ~mem_data;
            wait_r <= wait_r + 4'h1;
            if (poll_ack || vec_ack || mem_ack || !(poll_valid || vec_valid || mem_rd)) begin
                wait_r <= 4'h0;
            end else if (wait_r >= dly) begin
                wait_r <= 4'h0;
                if (poll_valid) begin
                    poll_ack <= 1'b1;
                    poll_resp <= (poll_level == adp_level) ? adp_mask : 4'h0;
                end else if (vec_valid) begin
                    vec_ack <= 1'b1;
                    vec_data <= {12'h002, vec_adapter, 2'h0};
                end else begin
                    mem_ack <= 1'b1;
                    mem_data <= mem[mem_addr[9:0]];
                end
            end
        end
    end
endmodule

// File: tb/tb.sv
// Self-checking bench: AHB-Lite register tasks and whole interrupt sequences.
// Assumes the adapter model answers every poll, vector and memory cycle.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import slpi_pkg::*;
    localparam logic [8:0] JS = 9'h0b4;
    localparam logic [8:0] XP = 9'h0ac;
    localparam logic [17:0] EB = 18'h100;
    localparam logic [31:0] LON = 32'h1 << C_LVL_ON;
    localparam logic [31:0] SON = 32'h1 << C_SYS_ON;
    localparam logic [31:0] CLR = 32'h1 << C_CLR_ALL;
    localparam logic [31:0] SETP = 32'h1 << C_SET_PREQ;
    localparam logic [31:0] CLRP = 32'h1 << C_CLR_PREQ;
    logic hclk, hresetn, hsel, hwrite, cpu_ready, hreadyout, hresp, prog_halt;
    logic poll_valid, poll_ack, vec_valid, vec_ack, mem_rd, mem_ack, start_valid;
    logic start_mode_from_flags, restore_valid, restore_from_dword;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans, vec_adapter;
    logic [2:0] hsize, poll_level, adp_level;
    logic [3:0] poll_resp, adp_mask, dly;
    logic [6:0] hw_req;
    logic [15:0] vec_data;
    logic [17:0] mem_addr, start_pc;
    logic [35:0] mem_data;
    int fail_count, total_checks;
    wire logic [2:0] evs = {start_valid, vec_valid, poll_valid};
    slpi_top #(.OPC_JSAVE(JS), .OPC_JUMP_AND_RESTORE(XP), .AC_EXCHANGE_PC_WORD(4'h5)) uut (.*, .hready(hreadyout));
    slpi_adapters pm (.*);
    always #4 hclk = ~hclk;
    function automatic logic [35:0] ins(logic [8:0] op, logic [3:0] ac, logic [17:0] y);
        return {op, ac, 5'h0, y};
    endfunction
    task automatic check(input string what, input logic [35:0] exp, input logic [35:0] got);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        hwrite <= wr;
        haddr <= {24'h0, a};
        htrans <= HTRANS_NONSEQ;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(what, {4'h0, exp}, {4'h0, q});
        check("hresp", 36'h0, 36'(hresp));
    endtask
    task automatic wait_ev(input int k, input string what);
        int n;
        n = 0;
        while (evs[k] !== 1'b1 && n < 300) begin
            @(posedge hclk);
            n++;
        end
        check(what, 36'h1, 36'(evs[k]));
    endtask
    task automatic wait_poll(input logic [2:0] lvl);
        wait_ev(0, "poll_valid");
        check("poll_level", 36'(lvl), 36'(poll_level));
        check("prog_halt", 36'h1, 36'(prog_halt));
    endtask
    task automatic wait_start(input logic [17:0] pc, input logic md);
        wait_ev(2, "start_valid");
        check("start_pc", 36'(pc), 36'(start_pc));
        check("start_mode", 36'(md), 36'(start_mode_from_flags));
    endtask
    task automatic quiet(input int n);
        logic seen;
        seen = 1'b0;
        repeat (n) begin
            @(posedge hclk);
            seen |= poll_valid;
        end
        check("poll_valid", 36'h0, 36'(seen));
    endtask
    task automatic dismiss(input logic x);
        wr(OFF_DISM, {31'h0, x});
        @(posedge hclk);
        check("restore_valid", 36'h1, 36'(restore_valid));
        check("restore_from_dword", 36'(x), 36'(restore_from_dword));
    endtask
    task automatic halt_wait(input logic [1:0] exp);
        logic [31:0] q;
        q = 32'h0;
        for (int i = 0; i < 40 && q[1:0] == 2'h0; i++) bus(1'b0, OFF_HALT, 32'h0, q);
        check("halt", 36'(exp), 36'(q[1:0]));
        check("prog_halt", 36'h1, 36'(prog_halt));
        hw_req <= 7'h0;
        wr(OFF_COND, CLR);
        rd("halt", OFF_HALT, 32'h0);
    endtask
    task automatic end_of_test();
        if (fail_count == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        hclk = 0;
        {hresetn, hwrite, haddr, htrans, hwdata, hw_req, adp_mask, adp_level, dly} = '0;
        {hsel, cpu_ready, hsize} = {2'h3, 3'h2};
        fail_count = 0;
        total_checks = 0;
        pm.mem[EB + EPT_LVL_BASE + 6] = ins(JS, 4'h0, 18'h200);
        pm.mem[EB + EPT_ADP_BASE + 1] = 36'h300;
        pm.mem[18'h309] = ins(XP, 4'h5, 18'h400);
        pm.mem[EB + EPT_LVL_BASE + 10] = ins(9'h0, 4'h0, 18'h0);
        pm.mem[EB + EPT_ADP_BASE + 3] = 36'hfff_fc0000;
        pm.mem[EB + EPT_LVL_BASE + 2] = ins(JS, 4'h0, 18'h500);
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        rd("status", OFF_STAT, 32'h0);
        rd("unmapped", 8'h40, 32'h0);
        wr(OFF_EPT, {14'h0, EB});
        rd("ept", OFF_EPT, {14'h0, EB});
        wr(OFF_COND, 32'h7f);
        rd("status", OFF_STAT, 32'h0);
        wr(OFF_COND, LON | SON | 32'h7f);
        rd("status", OFF_STAT, 32'hff);
        rd("cond", OFF_COND, 32'h0);
        hw_req <= 7'h04;
        wait_poll(3'h3);
        wait_start(18'h200, 1'b0);
        hw_req <= 7'h10;
        rd("status", OFF_STAT, 32'h10ff);
        quiet(20);
        {adp_level, adp_mask, dly} <= {3'h2, 4'ha, 4'h3};
        hw_req <= 7'h12;
        wait_poll(3'h2);
        wait_ev(1, "vec_valid");
        check("vec_adapter", 36'h1, 36'(vec_adapter));
        wait_start(18'h400, 1'b1);
        hw_req <= 7'h10;
        rd("status", OFF_STAT, 32'h30ff);
        dismiss(1'b1);
        rd("status", OFF_STAT, 32'h10ff);
        quiet(12);
        dismiss(1'b0);
        wait_poll(3'h5);
        halt_wait(2'h2);
        rd("status", OFF_STAT, 32'h0);
        wr(OFF_COND, LON | 32'h7f);
        {adp_level, adp_mask, dly} <= {3'h4, 4'h8, 4'h0};
        hw_req <= 7'h28;
        quiet(15);
        // The processor is busy mid-instruction, so nothing may be accepted yet.
        cpu_ready <= 1'b0;
        wr(OFF_COND, SON);
        quiet(8);
        cpu_ready <= 1'b1;
        wait_poll(3'h4);
        wait_ev(1, "vec_valid");
        check("vec_adapter", 36'h3, 36'(vec_adapter));
        halt_wait(2'h1);
        wr(OFF_COND, SON);
        hw_req <= 7'h01;
        quiet(12);
        hw_req <= 7'h0;
        wr(OFF_COND, SETP | 32'h40);
        wait_poll(3'h1);
        wait_start(18'h500, 1'b0);
        rd("status", OFF_STAT, 32'h0100_4080);
        dismiss(1'b0);
        wait_poll(3'h1);
        wait_start(18'h500, 1'b0);
        wr(OFF_COND, CLRP | 32'h40);
        rd("status", OFF_STAT, 32'h4080);
        dismiss(1'b0);
        quiet(12);
        rd("status", OFF_STAT, 32'h80);
        wr(OFF_COND, LON | 32'h7f);
        wr(OFF_COND, (32'h1 << C_SYS_OFF) | (32'h1 << C_LVL_OFF) | 32'h41);
        rd("status", OFF_STAT, 32'h3e);
        end_of_test();
    end
    // The sequences need a few hundred cycles; this 25000-cycle bound only catches a hang.
    initial begin
        #200000;
        fail_count++;
        end_of_test();
    end
endmodule
